//--- tbt_pkg.sv
// package for the reload down-timer block: register map, field positions,
// count-source codes and the structs that carry grouped signals.
// assumes a 10-bit byte address and a 16-bit register data path.
package tbt_pkg;

  // register byte addresses
  localparam logic [9:0] ADDR_RUN_CTRL  = 10'h380;  // timer_run_control
  localparam logic [9:0] ADDR_PRS_CTRL  = 10'h381;  // prescaler_reset_control
  localparam logic [9:0] ADDR_COUNT0    = 10'h390;  // channel 0 count, channel i at +2*i
  localparam logic [9:0] ADDR_COUNT_STEP = 10'h002; // spacing of count registers
  localparam logic [9:0] ADDR_SRC_SEL   = 10'h3a0;  // count-source select, 3 bits per channel
  localparam logic [9:0] ADDR_IRQ_STS   = 10'h3a1;  // sticky underflow status
  localparam logic [9:0] ADDR_IRQ_MSK   = 10'h3a2;  // interrupt mask

  // field positions
  localparam int RUN_A_LSB    = 0;  // group-A run flags, bits 2:0
  localparam int RUN_B_LSB    = 5;  // group-B run flags, bits 7:5
  localparam int PRS_RST_BIT  = 7;  // prescaler_reset_bit
  localparam int SRC_W        = 3;  // width of one source-select field

  // reset values
  localparam logic [7:0]  RUN_RST = 8'h00;
  localparam logic [8:0]  SRC_RST = 9'h000;
  localparam logic [2:0]  IRQ_RST = 3'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // divider terminal counts (divide by value + 1)
  localparam logic [4:0] DIV2_LAST  = 5'h01;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;

  // count-source select codes
  localparam logic [2:0] SRC_DIV1  = 3'h0;  // base_clock_div1
  localparam logic [2:0] SRC_DIV2  = 3'h1;  // base_clock_div2
  localparam logic [2:0] SRC_DIV8  = 3'h2;  // base_clock_div8
  localparam logic [2:0] SRC_DIV32 = 3'h3;  // base_clock_div32
  localparam logic [2:0] SRC_SUB32 = 3'h4;  // subclock_div32

  // one-cycle enables of the five count sources
  typedef struct packed {
    logic sub32;
    logic div32;
    logic div8;
    logic div2;
    logic div1;
  } tbt_ticks_type;

  // one register-bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } tbt_bus_req_type;

endpackage

//--- tbt_prescaler.sv
// count-source generator: base clock divided by 1, 2, 8, 32 and the
// subclock divided by 32, each as a one-cycle enable.
// assumes i_subclk is a slow level already synchronous to i_clk_sys.
`timescale 1ns/1ps
module tbt_prescaler (
  input  wire logic              i_clk_sys,  // system clock
  input  wire logic              i_srst,     // synchronous reset
  input  wire logic              i_subclk,   // subclock level
  input  wire logic              i_prs_clr,  // restart the timekeeping prescaler
  output tbt_pkg::tbt_ticks_type o_ticks     // count-source enables
);

  logic [4:0]            base_q, base_d;  // free-running base divider
  logic [4:0]            sub_q, sub_d;    // subclock edge counter
  logic                  subl_q, subl_d;  // last subclock level
  tbt_pkg::tbt_ticks_type tk_q, tk_d;     // registered enables

  // next-state of the dividers
  always_comb
  begin
    base_d       = base_q + 5'h01;
    subl_d       = i_subclk;
    sub_d        = sub_q;
    tk_d.div1    = 1'b1;
    tk_d.div2    = (base_q[0:0] == tbt_pkg::DIV2_LAST[0:0]);
    tk_d.div8    = (base_q[2:0] == tbt_pkg::DIV8_LAST[2:0]);
    tk_d.div32   = (base_q == tbt_pkg::DIV32_LAST);
    tk_d.sub32   = 1'b0;
    if (i_prs_clr)
    begin
      sub_d = 5'h00;  // prescaler reinitialised by software
    end
    else if (i_subclk && !subl_q)
    begin
      // count rising subclock edges
      sub_d = sub_q + 5'h01;
      if (sub_q == tbt_pkg::DIV32_LAST)
      begin
        tk_d.sub32 = 1'b1;
      end
    end
  end

  // register the dividers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      base_q <= 5'h00;
      sub_q  <= 5'h00;
      subl_q <= 1'b0;
      tk_q   <= '0;
    end
    else
    begin
      base_q <= base_d;
      sub_q  <= sub_d;
      subl_q <= subl_d;
      tk_q   <= tk_d;
    end
  end

  assign o_ticks = tk_q;

  a_div32_period : assert property (@(posedge i_clk_sys) disable iff (i_srst) tk_q.div32 |-> ##32 tk_q.div32)
    else $error("div32 enable not periodic");
  a_prs_clear : assert property (@(posedge i_clk_sys) disable iff (i_srst) i_prs_clr |=> sub_q == 5'h00)
    else $error("prescaler not cleared");

endmodule

//--- tbt_channel.sv
// one 16-bit reload down-counter in timer mode.
// assumes i_tick is a one-cycle enable from the selected count source.
`timescale 1ns/1ps
module tbt_channel (
  input  wire logic        i_clk_sys,  // system clock
  input  wire logic        i_srst,     // synchronous reset
  input  wire logic        i_run,      // channel_run_flag
  input  wire logic        i_tick,     // count-source enable
  input  wire logic        i_wr,       // write to channel_count_register
  input  wire logic [15:0] i_wdata,    // written value
  output logic      [15:0] o_count,    // present count
  output logic             o_uf        // underflow pulse, same edge as reload
);

  typedef enum logic [1:0] {ST_STOP, ST_ARMED, ST_COUNT} tbt_ch_state_type;

  tbt_ch_state_type st_q, st_d;       // stopped / started-no-tick / counting
  logic [15:0]      cnt_q, cnt_d;     // counter
  logic [15:0]      rld_q, rld_d;     // reload register
  logic             uf_q, uf_d;       // underflow pulse

  // next-state of the counter
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    rld_d = rld_q;
    uf_d  = 1'b0;
    unique case (st_q)
      ST_STOP:
      begin
        if (i_wr)
        begin
          rld_d = i_wdata;
          cnt_d = i_wdata;
        end
        if (i_run)
        begin
          st_d = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        if (i_wr)
        begin
          rld_d = i_wdata;
          cnt_d = i_wdata;
        end
        else if (i_tick)
        begin
          // first pulse counts like any other
          if (cnt_q == 16'h0000)
          begin
            cnt_d = rld_q;
            uf_d  = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
        if (!i_run)
        begin
          st_d = ST_STOP;
        end
        else if (i_tick)
        begin
          st_d = ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (i_wr)
        begin
          rld_d = i_wdata;
        end
        if (i_tick)
        begin
          if (cnt_q == 16'h0000)
          begin
            cnt_d = rld_q;
            uf_d  = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
        if (!i_run)
        begin
          st_d  = ST_STOP;
          cnt_d = cnt_q;    // halt holds the count
          uf_d  = 1'b0;
        end
      end
      default:
      begin
        st_d = ST_STOP;
      end
    endcase
  end

  // register the counter
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st_q  <= ST_STOP;
      cnt_q <= tbt_pkg::CNT_RST;
      rld_q <= tbt_pkg::CNT_RST;
      uf_q  <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      rld_q <= rld_d;
      uf_q  <= uf_d;
    end
  end

  assign o_count = cnt_q;
  assign o_uf    = uf_q;

  a_reload_on_uf : assert property (@(posedge i_clk_sys) disable iff (i_srst) (st_q == ST_COUNT && i_run && i_tick && cnt_q == 16'h0000) |=> (uf_q && cnt_q == $past(rld_q)))
    else $error("no reload on underflow");
  a_decrement : assert property (@(posedge i_clk_sys) disable iff (i_srst) (st_q == ST_COUNT && i_run && i_tick && cnt_q != 16'h0000) |=> (cnt_q == $past(cnt_q) - 16'h0001 && !uf_q))
    else $error("count did not decrement");
  a_hold_stopped : assert property (@(posedge i_clk_sys) disable iff (i_srst) (st_q == ST_STOP && !i_wr) |=> cnt_q == $past(cnt_q))
    else $error("stopped counter moved");
  a_write_idle : assert property (@(posedge i_clk_sys) disable iff (i_srst) (st_q != ST_COUNT && i_wr) |=> (cnt_q == $past(i_wdata) && rld_q == $past(i_wdata)))
    else $error("idle write not loaded in both");
  a_write_count : assert property (@(posedge i_clk_sys) disable iff (i_srst) (st_q == ST_COUNT && i_run && i_wr && !i_tick) |=> (cnt_q == $past(cnt_q) && rld_q == $past(i_wdata)))
    else $error("counting write touched counter");

endmodule

//--- tbt_timer.sv
// top of the reload down-timer block: register slave, count-source
// selection, three counters and the underflow interrupt.
// assumes a master that issues one-cycle strobes and reads data one
// cycle after the read strobe; never waits.
`timescale 1ns/1ps
module tbt_timer (
  input  wire logic        i_clk_sys,     // system clock, 125 MHz
  input  wire logic        i_srst,        // synchronous reset, active high
  input  wire logic [9:0]  i_addr,        // register byte address
  input  wire logic [15:0] i_wdata,       // write data
  input  wire logic        i_wr,          // write strobe
  input  wire logic        i_rd,          // read strobe
  input  wire logic        i_subclk,      // subclock level
  output logic      [15:0] o_rdata,       // read data, cycle after i_rd
  output logic             o_irq,         // level interrupt
  output logic      [2:0]  o_group_a_run, // group-A run flags to that group
  output logic      [2:0]  o_underflow    // per-channel underflow pulses
);

  // packed bus request
  tbt_pkg::tbt_bus_req_type req;          // incoming request
  tbt_pkg::tbt_ticks_type   ticks;        // count-source enables

  // register state
  logic [7:0]  run_q, run_d;              // timer_run_control
  logic [8:0]  src_q, src_d;              // source select fields
  logic [2:0]  sts_q, sts_d;              // sticky underflow status
  logic [2:0]  msk_q, msk_d;              // interrupt mask
  logic [15:0] rdata_q, rdata_d;          // read data
  logic        irq_q, irq_d;              // interrupt output
  logic        prs_clr;                   // prescaler restart pulse

  // per-channel wiring
  logic [15:0] cnt [3];                   // present counts
  logic [2:0]  uf;                        // underflow pulses
  logic [2:0]  tick;                      // selected enables
  logic [2:0]  cnt_wr;                    // count register writes

  assign req.wr    = i_wr;
  assign req.rd    = i_rd;
  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;

  // timekeeping prescaler restarts on a one written to its bit
  assign prs_clr = req.wr && (req.addr == tbt_pkg::ADDR_PRS_CTRL)
                   && req.wdata[tbt_pkg::PRS_RST_BIT];

  // count-source generator
  tbt_prescaler u_prescaler (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_subclk  (i_subclk),
    .i_prs_clr (prs_clr),
    .o_ticks   (ticks)
  );

  // one counter per channel; no external input pin reaches them
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ch
      logic [2:0] sel;                    // this channel's source code
      assign sel = src_q[gi*tbt_pkg::SRC_W +: tbt_pkg::SRC_W];
      // pick one of five internal sources
      always_comb
      begin
        case (sel)
          tbt_pkg::SRC_DIV1:  tick[gi] = ticks.div1;
          tbt_pkg::SRC_DIV2:  tick[gi] = ticks.div2;
          tbt_pkg::SRC_DIV8:  tick[gi] = ticks.div8;
          tbt_pkg::SRC_DIV32: tick[gi] = ticks.div32;
          tbt_pkg::SRC_SUB32: tick[gi] = ticks.sub32;
          default:            tick[gi] = 1'b0;  // unused codes give no pulses
        endcase
      end
      // count register write decode
      assign cnt_wr[gi] = req.wr && (req.addr == tbt_pkg::ADDR_COUNT0
                          + tbt_pkg::ADDR_COUNT_STEP * 10'(gi));
      // counter; only internal enables feed it
      tbt_channel u_ch (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_run     (run_q[tbt_pkg::RUN_B_LSB + gi]),
        .i_tick    (tick[gi]),
        .i_wr      (cnt_wr[gi]),
        .i_wdata   (req.wdata),
        .o_count   (cnt[gi]),
        .o_uf      (uf[gi])
      );
    end
  endgenerate

  // register writes, status capture and read mux
  always_comb
  begin
    run_d   = run_q;
    src_d   = src_q;
    msk_d   = msk_q;
    rdata_d = 16'h0000;
    // sticky status: a write of one clears, a new underflow wins
    sts_d   = sts_q;
    if (req.wr && req.addr == tbt_pkg::ADDR_IRQ_STS)
    begin
      sts_d = sts_q & ~req.wdata[2:0];
    end
    sts_d = sts_d | uf;
    if (req.wr)
    begin
      unique case (req.addr)
        tbt_pkg::ADDR_RUN_CTRL:
        begin
          run_d[tbt_pkg::RUN_B_LSB +: 3] = req.wdata[tbt_pkg::RUN_B_LSB +: 3];
          run_d[tbt_pkg::RUN_A_LSB +: 3] = req.wdata[tbt_pkg::RUN_A_LSB +: 3];
          run_d[4:3] = 2'h0;
        end
        tbt_pkg::ADDR_SRC_SEL:
        begin
          src_d = req.wdata[8:0];
        end
        tbt_pkg::ADDR_IRQ_MSK:
        begin
          msk_d = req.wdata[2:0];
        end
        default:
        begin
          // other addresses store nothing here
        end
      endcase
    end
    if (req.rd)
    begin
      unique case (req.addr)
        tbt_pkg::ADDR_RUN_CTRL: rdata_d = {8'h00, run_q};
        tbt_pkg::ADDR_PRS_CTRL: rdata_d = 16'h0000;
        tbt_pkg::ADDR_SRC_SEL:  rdata_d = {7'h00, src_q};
        tbt_pkg::ADDR_IRQ_STS:  rdata_d = {13'h0000, sts_q};
        tbt_pkg::ADDR_IRQ_MSK:  rdata_d = {13'h0000, msk_q};
        tbt_pkg::ADDR_COUNT0:   rdata_d = cnt[0];
        tbt_pkg::ADDR_COUNT0 + tbt_pkg::ADDR_COUNT_STEP:
          rdata_d = cnt[1];
        tbt_pkg::ADDR_COUNT0 + 10'h004:
          rdata_d = cnt[2];
        default:                rdata_d = 16'h0000;  // unmapped reads zero
      endcase
    end
    irq_d = |(sts_d & msk_d);
  end

  // register the slave state
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      run_q   <= tbt_pkg::RUN_RST;
      src_q   <= tbt_pkg::SRC_RST;
      sts_q   <= tbt_pkg::IRQ_RST;
      msk_q   <= tbt_pkg::IRQ_RST;
      rdata_q <= 16'h0000;
      irq_q   <= 1'b0;
    end
    else
    begin
      run_q   <= run_d;
      src_q   <= src_d;
      sts_q   <= sts_d;
      msk_q   <= msk_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_irq         = irq_q;
  assign o_group_a_run = run_q[tbt_pkg::RUN_A_LSB +: 3];
  assign o_underflow   = uf;

  a_run_write : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_wr && i_addr == tbt_pkg::ADDR_RUN_CTRL) |=> (run_q[7:5] == $past(i_wdata[7:5])))
    else $error("group-B run flags not written");
  a_run_a_out : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_wr && i_addr == tbt_pkg::ADDR_RUN_CTRL) |=> (o_group_a_run == $past(i_wdata[2:0])))
    else $error("group-A run flags not written");
  a_gap_zero : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == tbt_pkg::ADDR_RUN_CTRL) |=> (o_rdata[4:3] == 2'h0))
    else $error("unassigned run bits not zero");
  a_prs_read : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == tbt_pkg::ADDR_PRS_CTRL) |=> (o_rdata == 16'h0000))
    else $error("prescaler register read nonzero");
  a_count_read : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == tbt_pkg::ADDR_COUNT0) |=> (o_rdata == $past(cnt[0])))
    else $error("count read mismatch");
  a_uf_status : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    uf[0] |=> sts_q[0])
    else $error("underflow did not set status");
  a_irq_level : assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (|(sts_q & msk_q)) |-> o_irq)
    else $error("interrupt low with pending status");

endmodule

//--- tbt_timer_bench.sv
// self-checking bench for the reload down-timer block: register map,
// start/stop, divide ratio, reload-on-write behaviour, sources and interrupt.
// assumes the design files and tbt_pkg are compiled before this file.
`timescale 1ns/1ps
module tbt_timer_bench;

  // one table row: register address, value written, value read back
  typedef struct packed {
    logic [9:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } tbt_row_type;

  logic        i_clk_sys = 1'b0;    // system clock
  logic        i_srst    = 1'b1;    // synchronous reset
  logic [9:0]  i_addr    = 10'h000; // register address
  logic [15:0] i_wdata   = 16'h0000; // write data
  logic        i_wr      = 1'b0;    // write strobe
  logic        i_rd      = 1'b0;    // read strobe
  logic        i_subclk  = 1'b0;    // subclock level
  logic [15:0] o_rdata;             // read data
  logic        o_irq;               // interrupt level
  logic [2:0]  o_group_a_run;       // group-A run flags
  logic [2:0]  o_underflow;         // underflow pulses
  int          err_total = 0;       // mismatches
  int          checked   = 0;       // comparisons
  int          cyc       = 0;       // cycle counter for the hang guard
  logic [3:0]  sc_cnt    = 4'h0;    // subclock divider
  logic [15:0] g;                   // measured gap or read value
  logic [15:0] h;                   // second read value

  // register table: write then read back
  tbt_row_type rows [9] = '{
    '{tbt_pkg::ADDR_RUN_CTRL, 16'h00e7, 16'h00e7},
    '{tbt_pkg::ADDR_RUN_CTRL, 16'h0000, 16'h0000},
    '{tbt_pkg::ADDR_PRS_CTRL, 16'h0080, 16'h0000},
    '{tbt_pkg::ADDR_IRQ_MSK,  16'h0007, 16'h0007},
    '{tbt_pkg::ADDR_IRQ_MSK,  16'h0000, 16'h0000},
    '{tbt_pkg::ADDR_SRC_SEL,  16'h0124, 16'h0124},
    '{tbt_pkg::ADDR_SRC_SEL,  16'h0000, 16'h0000},
    '{10'h3ff,                16'h1234, 16'h0000},
    '{tbt_pkg::ADDR_COUNT0,   16'h0005, 16'h0005}
  };
  logic [15:0] src_gap [4] = '{16'h0001, 16'h0002, 16'h0008, 16'h0020}; // period per source code

  tbt_timer u_dut (
    .i_clk_sys     (i_clk_sys),
    .i_srst        (i_srst),
    .i_addr        (i_addr),
    .i_wdata       (i_wdata),
    .i_wr          (i_wr),
    .i_rd          (i_rd),
    .i_subclk      (i_subclk),
    .o_rdata       (o_rdata),
    .o_irq         (o_irq),
    .o_group_a_run (o_group_a_run),
    .o_underflow   (o_underflow)
  );

  // clock, 8 ns period
  always #4 i_clk_sys = ~i_clk_sys;

  // subclock with a period of 8 system cycles
  always @(posedge i_clk_sys)
  begin
    sc_cnt   <= sc_cnt + 4'h1;
    i_subclk <= sc_cnt[2];
  end

  // hang guard
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  // verdict and end of run
  task automatic end_sim;
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [9:0] a, output logic [15:0] q);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    q = o_rdata;
  endtask

  // cycles from one underflow pulse of a channel to the next
  task automatic gap(input int ch, output logic [15:0] n);
    int k;
    n = 16'h0000;
    k = 0;
    while (o_underflow[ch] !== 1'b1 && k < 2000)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    do
    begin
      @(negedge i_clk_sys);
      n++;
    end while (o_underflow[ch] !== 1'b1 && n < 16'd2000);
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(posedge i_clk_sys);
    // every register reads zero after reset
    for (int i = 0; i < 8; i++)
    begin
      rd(i < 2 ? tbt_pkg::ADDR_RUN_CTRL + 10'(i) : i < 5 ? tbt_pkg::ADDR_COUNT0 + 10'(2 * (i - 2))
         : tbt_pkg::ADDR_SRC_SEL + 10'(i - 5), g);
      chk(g, 16'h0000);
    end
    // table rows
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, g);
      chk(g, rows[i].e);
    end
    // group-A flags reach their outputs
    wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0007);
    @(negedge i_clk_sys);
    chk({13'h0000, o_group_a_run}, 16'h0007);
    wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0000);
    wr(tbt_pkg::ADDR_IRQ_STS, 16'h0007);
    // channel 0, n = 3, base clock: underflow every 4 cycles
    wr(tbt_pkg::ADDR_COUNT0, 16'h0003);
    wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0020);
    gap(0, g);
    gap(0, g);
    chk(g, 16'h0004);
    // status set, interrupt held off by the mask, then let through
    rd(tbt_pkg::ADDR_IRQ_STS, g);
    chk(g, 16'h0001);
    chk({15'h0000, o_irq}, 16'h0000);
    wr(tbt_pkg::ADDR_IRQ_MSK, 16'h0001);
    @(negedge i_clk_sys);
    chk({15'h0000, o_irq}, 16'h0001);
    // write while counting only changes the reload value
    wr(tbt_pkg::ADDR_COUNT0, 16'h0001);
    // the first gap may still end on the old reload value
    gap(0, g);
    gap(0, g);
    chk(g, 16'h0002);
    // stop holds the count
    wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0000);
    rd(tbt_pkg::ADDR_COUNT0, g);
    repeat (10) @(posedge i_clk_sys);
    rd(tbt_pkg::ADDR_COUNT0, h);
    chk(h, g);
    chk({13'h0000, o_underflow}, 16'h0000);
    // clear status by writing one
    wr(tbt_pkg::ADDR_IRQ_STS, 16'h0001);
    rd(tbt_pkg::ADDR_IRQ_STS, g);
    chk(g, 16'h0000);
    chk({15'h0000, o_irq}, 16'h0000);
    // base-clock sources on channel 2 with n = 0
    for (int i = 0; i < 4; i++)
    begin
      wr(tbt_pkg::ADDR_SRC_SEL, 16'(i) << 6);
      wr(tbt_pkg::ADDR_COUNT0 + 10'h004, 16'h0000);
      wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0080);
      gap(2, g);
      chk(g, src_gap[i]);
      wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0000);
    end
    // subclock source: restart its prescaler, write before the first pulse
    wr(tbt_pkg::ADDR_SRC_SEL, 16'h0100);
    wr(tbt_pkg::ADDR_PRS_CTRL, 16'h0080);
    wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0080);
    wr(tbt_pkg::ADDR_COUNT0 + 10'h004, 16'h0009);
    rd(tbt_pkg::ADDR_COUNT0 + 10'h004, g);
    chk(g, 16'h0009);
    wr(tbt_pkg::ADDR_COUNT0 + 10'h004, 16'h0000);
    gap(2, g);
    chk(g, 16'h0100);
    wr(tbt_pkg::ADDR_RUN_CTRL, 16'h0000);
    end_sim();
  end

endmodule
